/* File: logic/mbt_regs.svh */
`ifndef MBT_REGS_SVH
`define MBT_REGS_SVH

// Register indices; the byte address of each register is four times its index.
`define MBT_IDX_TIMEOUT 8'h14
`define MBT_IDX_RESTART_SEL 8'h15
`define MBT_IDX_HALF_ORDER 8'h16
`define MBT_IDX_RSVD_FIRST 8'h17
`define MBT_IDX_RSVD_LAST 8'h1A
`define MBT_IDX_APPLY 8'h1B
`define MBT_IDX_TABLE_REV 8'h1C
`define MBT_IDX_TYPE_CODE 8'h1D
`define MBT_IDX_STATUS 8'h20
`define MBT_IDX_LONG_VALUE 8'h21
`define MBT_IDX_TX_WORDS 8'h22

// Reset values of the adapter settings.
`define MBT_RST_TIMEOUT 16'h0014
`define MBT_RST_RESTART_SEL 2'h2
`define MBT_RST_HALF_ORDER 1'h1

// Restart select encodings.
`define MBT_SEL_NONE 2'h0
`define MBT_SEL_ANY 2'h1
`define MBT_SEL_CONTROL 2'h2
`define MBT_SEL_MAX 16'h0002

// Long value half order encodings.
`define MBT_LOW_HALF_FIRST 1'h0
`define MBT_HIGH_HALF_FIRST 1'h1
`define MBT_HALF_MAX 16'h0001

// Status register bit positions.
`define MBT_ST_LOST 0
`define MBT_ST_RUNNING 1
`define MBT_ST_BUSY 2
`define MBT_ST_CFG_ERR 3

// Bus responses.
`define MBT_RESP_OKAY 2'h0
`define MBT_RESP_SLVERR 2'h2

// Supervision tick timing.
`define MBT_REF_CLK_HZ 25000000
`define MBT_TICK_MS 100
`define MBT_TICK_CYCLES ((`MBT_REF_CLK_HZ / 1000) * `MBT_TICK_MS)

`endif

/* File: logic/mbt_pkg.sv */
package mbt_pkg;

  typedef enum logic [2:0]
  {
    MBT_AP_IDLE = 3'h1,
    MBT_AP_CHECK = 3'h2,
    MBT_AP_ADOPT = 3'h4
  } mbt_apply_e;

  typedef logic [15:0] mbt_word_t;

endpackage

/* File: logic/mbt_cfg_if.sv */
`timescale 1ns/1ps

interface mbt_cfg_if;
  logic [1:0] restartSel;
  logic [15:0] timeoutValue;
  logic halfOrder;
  logic [31:0] longValue;
  logic lost;
  logic [15:0] firstWord;
  logic [15:0] secondWord;
  logic [31:0] txBytes;

  modport ctrl
  (
    output restartSel, timeoutValue, halfOrder, longValue,
    input lost, firstWord, secondWord, txBytes
  );
  modport sup
  (
    input restartSel, timeoutValue,
    output lost
  );
  modport order
  (
    input halfOrder, longValue,
    output firstWord, secondWord, txBytes
  );
endinterface

/* File: logic/mbt_supervisor.sv */
`timescale 1ns/1ps
`include "mbt_regs.svh"

module mbt_supervisor
#(
  parameter int unsigned TICK_CYCLES = `MBT_TICK_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  mbt_cfg_if.sup cfg,
  input wire logic anyAccess,
  input wire logic controlAccess
);
  logic [23:0] prescale;
  logic [15:0] tickCount;
  wire tick = (prescale == 24'(TICK_CYCLES - 1));
  wire enabled = (cfg.restartSel != `MBT_SEL_NONE) && (cfg.timeoutValue != 16'h0000);
  wire restartAny = (cfg.restartSel == `MBT_SEL_ANY) && (anyAccess || controlAccess);
  wire restartCtl = (cfg.restartSel == `MBT_SEL_CONTROL) && controlAccess;
  wire restart = restartAny || restartCtl;

  // loss told to drive
  // A count already past a newly adopted shorter timeout also counts as expired.
  assign cfg.lost = enabled && (tickCount >= cfg.timeoutValue);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prescale <= 24'h000000;
      tickCount <= 16'h0000;
    end
    else if (!enabled || restart)
    begin
      prescale <= 24'h000000;
      tickCount <= 16'h0000;
    end
    else if (tick)
    begin
      prescale <= 24'h000000;
      if (tickCount < cfg.timeoutValue)
        tickCount <= tickCount + 16'h0001;
    end
    else
      prescale <= prescale + 24'h000001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_MODE_NONE: assert property (cfg.restartSel == `MBT_SEL_NONE |-> !cfg.lost)
    else $error("Loss reported with supervision off.");
  AST_ANY_RESTART: assert property ((cfg.restartSel == `MBT_SEL_ANY) && anyAccess
    |=> (tickCount == 16'h0000) && (prescale == 24'h000000))
    else $error("Any access did not restart the counter.");
  AST_CTRL_ONLY: assert property ((cfg.restartSel == `MBT_SEL_CONTROL) && anyAccess
    && !controlAccess && enabled && !tick && $stable(cfg.restartSel)
    |=> tickCount == $past(tickCount))
    else $error("Plain access restarted the counter.");
  AST_ZERO_OFF: assert property (cfg.timeoutValue == 16'h0000 |-> !cfg.lost)
    else $error("Loss reported with zero timeout.");
  AST_LOST_HOLD: assert property (cfg.lost && !restart
    |=> cfg.lost || $changed(cfg.timeoutValue) || $changed(cfg.restartSel))
    else $error("Loss dropped without a restart.");
endmodule

/* File: logic/mbt_word_order.sv */
`timescale 1ns/1ps
`include "mbt_regs.svh"

module mbt_word_order
(
  input wire logic ref_clk,
  input wire logic reset_n,
  mbt_cfg_if.order cfg
);
  wire [15:0] next_firstWord = (cfg.halfOrder == `MBT_HIGH_HALF_FIRST) ?
    cfg.longValue[31:16] : cfg.longValue[15:0];
  wire [15:0] next_secondWord = (cfg.halfOrder == `MBT_HIGH_HALF_FIRST) ?
    cfg.longValue[15:0] : cfg.longValue[31:16];

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg.firstWord <= 16'h0000;
      cfg.secondWord <= 16'h0000;
      cfg.txBytes <= 32'h00000000;
    end
    else
    begin
      cfg.firstWord <= next_firstWord;
      cfg.secondWord <= next_secondWord;
      cfg.txBytes <= {next_firstWord[15:8], next_firstWord[7:0],
        next_secondWord[15:8], next_secondWord[7:0]};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_BYTE_ORDER: assert property (1'b1 |=> cfg.txBytes[31:24] == cfg.firstWord[15:8]
    && cfg.txBytes[15:8] == cfg.secondWord[15:8])
    else $error("High byte not sent first.");
  AST_LOW_FIRST: assert property (cfg.halfOrder == `MBT_LOW_HALF_FIRST
    |=> cfg.firstWord == $past(cfg.longValue[15:0]))
    else $error("Low half not in first register.");
  AST_HIGH_FIRST: assert property (cfg.halfOrder == `MBT_HIGH_HALF_FIRST
    |=> cfg.firstWord == $past(cfg.longValue[31:16]))
    else $error("High half not in first register.");
endmodule

/* File: logic/mbt_adapter.sv */
`timescale 1ns/1ps
`include "mbt_regs.svh"

// What this block does
// - Restart select zero disables timeout supervision; no loss is ever reported.
// - Restart select one restarts the timeout on any client register access.
// - Restart select two, the default, restarts only on new command or setpoint.
// - Each 16-bit register is sent high byte first, low byte second.
// - Half order zero puts the low word in the first register.
// - Half order one, the default, puts the high word in the first register.
// - Writing one to the apply trigger validates and adopts settings, then clears.
// - Apply trigger changes are refused while the drive is running.
// - Read-only parameter table revision of the stored mapping file is exposed.
// - Read-only drive type code is exposed; writes to it do nothing.
// - Settings at positions 23 through 26 are ignored and reserved.
// - Timeout is the configured value times 100 ms; zero disables it.
// - On timeout expiry the drive is told that client communication is lost.
module mbt_adapter
#(
  parameter int unsigned TICK_CYCLES = `MBT_TICK_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clientAnyAccess,
  input wire logic clientNewControl,
  input wire logic clientNewPrimarySetpoint,
  input wire logic clientNewSecondarySetpoint,
  input wire logic driveRunning,
  input wire logic [15:0] tableRevision,
  input wire logic [15:0] driveTypeCode,
  output logic commLost,
  output logic [15:0] firstRegWord,
  output logic [15:0] secondRegWord,
  output logic [31:0] txByteStream,
  output logic configBusy
);
  mbt_cfg_if cfg();

  // Write channel holding registers; address and data may arrive in either order.
  logic awHeld;
  logic [7:0] awIndex;
  logic wHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // Settings written by software; all but longValue are adopted on apply, longValue takes effect at once.
  mbt_pkg::mbt_word_t pendTimeout;
  mbt_pkg::mbt_word_t pendSel;
  mbt_pkg::mbt_word_t pendHalf;
  logic [31:0] longValue;

  // Settings in force.
  logic [1:0] activeSel;
  mbt_pkg::mbt_word_t activeTimeout;
  logic activeHalf;

  mbt_pkg::mbt_apply_e applyState;
  mbt_pkg::mbt_apply_e next_applyState;
  logic cfgErr;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire [15:0] wMask = {{8{wStrb[1]}}, {8{wStrb[0]}}};
  wire [15:0] wLow = wData[15:0];
  wire [7:0] rIndex = s_axi_araddr[9:2];
  wire doRead = s_axi_arvalid && s_axi_arready;

  // Write decode.
  wire wrTimeout = doWrite && (awIndex == `MBT_IDX_TIMEOUT);
  wire wrSel = doWrite && (awIndex == `MBT_IDX_RESTART_SEL);
  wire wrHalf = doWrite && (awIndex == `MBT_IDX_HALF_ORDER);
  wire wrApply = doWrite && (awIndex == `MBT_IDX_APPLY);
  wire wrLong = doWrite && (awIndex == `MBT_IDX_LONG_VALUE);
  wire wrRsvd = (awIndex >= `MBT_IDX_RSVD_FIRST) && (awIndex <= `MBT_IDX_RSVD_LAST);
  wire wrReadOnly = (awIndex == `MBT_IDX_TABLE_REV) || (awIndex == `MBT_IDX_TYPE_CODE) ||
    (awIndex == `MBT_IDX_STATUS) || (awIndex == `MBT_IDX_TX_WORDS);
  wire wMapped = (awIndex == `MBT_IDX_TIMEOUT) || (awIndex == `MBT_IDX_RESTART_SEL) ||
    (awIndex == `MBT_IDX_HALF_ORDER) || (awIndex == `MBT_IDX_APPLY) ||
    (awIndex == `MBT_IDX_LONG_VALUE) || wrRsvd || wrReadOnly;
  wire applyIdle = (applyState == mbt_pkg::MBT_AP_IDLE);
  wire applyRefused = wrApply && driveRunning && wStrb[0];
  wire applyStart = wrApply && !driveRunning && applyIdle && wStrb[0] && wLow[0];
  wire [1:0] next_bresp = (!wMapped || applyRefused) ? `MBT_RESP_SLVERR : `MBT_RESP_OKAY;

  // Read decode.
  wire rRsvd = (rIndex >= `MBT_IDX_RSVD_FIRST) && (rIndex <= `MBT_IDX_RSVD_LAST);
  wire [31:0] statusWord = {28'h0000000, cfgErr, !applyIdle, driveRunning, cfg.lost};
  wire [31:0] applyWord = {31'h00000000, !applyIdle};
  wire [31:0] rdMux =
    (rIndex == `MBT_IDX_TIMEOUT) ? {16'h0000, pendTimeout} :
    (rIndex == `MBT_IDX_RESTART_SEL) ? {16'h0000, pendSel} :
    (rIndex == `MBT_IDX_HALF_ORDER) ? {16'h0000, pendHalf} :
    (rIndex == `MBT_IDX_APPLY) ? applyWord :
    (rIndex == `MBT_IDX_TABLE_REV) ? {16'h0000, tableRevision} :
    (rIndex == `MBT_IDX_TYPE_CODE) ? {16'h0000, driveTypeCode} :
    (rIndex == `MBT_IDX_STATUS) ? statusWord :
    (rIndex == `MBT_IDX_LONG_VALUE) ? longValue :
    (rIndex == `MBT_IDX_TX_WORDS) ? {cfg.firstWord, cfg.secondWord} :
    32'h00000000;
  wire rMapped = rRsvd || (rIndex == `MBT_IDX_TIMEOUT) ||
    (rIndex == `MBT_IDX_RESTART_SEL) || (rIndex == `MBT_IDX_HALF_ORDER) ||
    (rIndex == `MBT_IDX_APPLY) || (rIndex == `MBT_IDX_TABLE_REV) ||
    (rIndex == `MBT_IDX_TYPE_CODE) || (rIndex == `MBT_IDX_STATUS) ||
    (rIndex == `MBT_IDX_LONG_VALUE) || (rIndex == `MBT_IDX_TX_WORDS);

  // Validation rejects selects and half orders outside their encodings.
  wire pendValid = (pendSel <= `MBT_SEL_MAX) && (pendHalf <= `MBT_HALF_MAX);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHeld <= 1'b0;
      awIndex <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld <= 1'b1;
      awIndex <= s_axi_awaddr[9:2];
    end
    else if (doWrite)
      awHeld <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
    else if (doWrite)
      wHeld <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MBT_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_bresp;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MBT_RESP_OKAY;
    end
    else if (doRead)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rMapped ? `MBT_RESP_OKAY : `MBT_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendTimeout <= `MBT_RST_TIMEOUT;
      pendSel <= {14'h0000, `MBT_RST_RESTART_SEL};
      pendHalf <= {15'h0000, `MBT_RST_HALF_ORDER};
      longValue <= 32'h00000000;
    end
    else
    begin
      if (wrTimeout)
        pendTimeout <= (pendTimeout & ~wMask) | (wLow & wMask);
      if (wrSel)
        pendSel <= (pendSel & ~wMask) | (wLow & wMask);
      if (wrHalf)
        pendHalf <= (pendHalf & ~wMask) | (wLow & wMask);
      if (wrLong)
        longValue <= wData;
    end
  end

  always_comb
  begin
    next_applyState = applyState;
    case (applyState)
      mbt_pkg::MBT_AP_IDLE:
        if (applyStart)
          next_applyState = mbt_pkg::MBT_AP_CHECK;
      mbt_pkg::MBT_AP_CHECK:
        next_applyState = pendValid ? mbt_pkg::MBT_AP_ADOPT : mbt_pkg::MBT_AP_IDLE;
      mbt_pkg::MBT_AP_ADOPT:
        next_applyState = mbt_pkg::MBT_AP_IDLE;
      default:
        next_applyState = mbt_pkg::MBT_AP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      applyState <= mbt_pkg::MBT_AP_IDLE;
    else
      applyState <= next_applyState;
  end

  // A rejected check leaves the settings in force untouched and flags the error.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfgErr <= 1'b0;
    else if (applyState == mbt_pkg::MBT_AP_CHECK)
      cfgErr <= !pendValid;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      activeSel <= `MBT_RST_RESTART_SEL;
      activeTimeout <= `MBT_RST_TIMEOUT;
      activeHalf <= `MBT_RST_HALF_ORDER;
    end
    else if (applyState == mbt_pkg::MBT_AP_ADOPT)
    begin
      activeSel <= pendSel[1:0];
      activeTimeout <= pendTimeout;
      activeHalf <= pendHalf[0];
    end
  end

  assign cfg.restartSel = activeSel;
  assign cfg.timeoutValue = activeTimeout;
  assign cfg.halfOrder = activeHalf;
  assign cfg.longValue = longValue;

  wire controlAccess = clientNewControl || clientNewPrimarySetpoint ||
    clientNewSecondarySetpoint;

  mbt_supervisor #(.TICK_CYCLES(TICK_CYCLES)) supervisor
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cfg(cfg),
    .anyAccess(clientAnyAccess),
    .controlAccess(controlAccess)
  );

  mbt_word_order wordOrder
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cfg(cfg)
  );

  assign commLost = cfg.lost;
  assign firstRegWord = cfg.firstWord;
  assign secondRegWord = cfg.secondWord;
  assign txByteStream = cfg.txBytes;
  assign configBusy = !applyIdle;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_APPLY_CLEARS: assert property (applyStart |=> !applyIdle ##[1:2] applyIdle)
    else $error("Apply trigger did not return to zero.");
  AST_APPLY_ADOPTS: assert property (applyState == mbt_pkg::MBT_AP_ADOPT
    |=> activeSel == $past(pendSel[1:0]) && activeTimeout == $past(pendTimeout))
    else $error("Apply did not adopt pending settings.");
  AST_RUN_REFUSE: assert property (applyRefused && applyIdle
    |=> applyIdle && s_axi_bvalid && s_axi_bresp == `MBT_RESP_SLVERR)
    else $error("Apply change taken while running.");
  AST_TABLE_REV: assert property (doRead && rIndex == `MBT_IDX_TABLE_REV
    |=> s_axi_rdata == {16'h0000, $past(tableRevision)})
    else $error("Table revision readback wrong.");
  AST_TYPE_CODE: assert property (doRead && rIndex == `MBT_IDX_TYPE_CODE
    |=> s_axi_rdata == {16'h0000, $past(driveTypeCode)} && s_axi_rresp == `MBT_RESP_OKAY)
    else $error("Type code readback wrong.");
  AST_RSVD_ZERO: assert property (doRead && rRsvd
    |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == `MBT_RESP_OKAY)
    else $error("Reserved setting did not read zero.");
  AST_LOSS_OUT: assert property (commLost |-> activeSel != `MBT_SEL_NONE
    && activeTimeout != 16'h0000)
    else $error("Loss reported while supervision off.");

  COV_APPLY_DONE: cover property (applyState == mbt_pkg::MBT_AP_ADOPT ##1 applyIdle);
  COV_LOSS: cover property ($rose(commLost));
  COV_REFUSED: cover property (applyRefused);
  COV_CFG_ERR: cover property ($rose(cfgErr));
endmodule

/* File: dv/mbt_client_model.sv */
`timescale 1ns/1ps

// Stands in for the network client and the drive that sit around the adapter.
module mbt_client_model
(
  input wire logic ref_clk,
  output logic clientAnyAccess,
  output logic clientNewControl,
  output logic clientNewPrimarySetpoint,
  output logic clientNewSecondarySetpoint,
  output logic driveRunning
);
  initial
  begin
    clientAnyAccess = 1'b0;
    clientNewControl = 1'b0;
    clientNewPrimarySetpoint = 1'b0;
    clientNewSecondarySetpoint = 1'b0;
    driveRunning = 1'b0;
  end

  // Raises the chosen access strobes for exactly one cycle, then releases them.
  task automatic send(input logic [3:0] ev);
    begin
      {clientAnyAccess, clientNewControl, clientNewPrimarySetpoint,
        clientNewSecondarySetpoint} <= ev;
      @(posedge ref_clk);
      {clientAnyAccess, clientNewControl, clientNewPrimarySetpoint,
        clientNewSecondarySetpoint} <= 4'h0;
    end
  endtask

  task automatic set_run(input logic r);
    begin
      driveRunning <= r;
      @(posedge ref_clk);
    end
  endtask
endmodule

/* File: dv/mbt_adapter_tb_top.sv */
`timescale 1ns/1ps
`include "mbt_regs.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module mbt_adapter_tb_top;
  localparam int unsigned TICKS = 10;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, commLost, configBusy;
  logic [1:0] bresp, rresp, eb;
  logic [31:0] rdata, txByteStream, lv, seed = 32'h1FB10C95;
  logic [15:0] firstRegWord, secondRegWord, tableRevision, driveTypeCode;
  logic anyAcc, newCtl, newPri, newSec, driveRunning;
  logic [33:0] er;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [3:0] kinds[4] = '{4'h8, 4'hC, 4'hA, 4'h9};
  int errors = 0;
  int samplesChecked = 0;

  always #20 ref_clk = ~ref_clk;

  mbt_client_model u_client
  (
    .ref_clk(ref_clk), .clientAnyAccess(anyAcc), .clientNewControl(newCtl),
    .clientNewPrimarySetpoint(newPri), .clientNewSecondarySetpoint(newSec),
    .driveRunning(driveRunning)
  );

  mbt_adapter #(.TICK_CYCLES(TICKS)) DUT
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clientAnyAccess(anyAcc), .clientNewControl(newCtl),
    .clientNewPrimarySetpoint(newPri), .clientNewSecondarySetpoint(newSec),
    .driveRunning(driveRunning), .tableRevision(tableRevision),
    .driveTypeCode(driveTypeCode), .commLost(commLost), .firstRegWord(firstRegWord),
    .secondRegWord(secondRegWord), .txByteStream(txByteStream), .configBusy(configBusy)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compares each bus answer against the oldest expectation noted by the driver.
  always @(posedge ref_clk)
  begin
    if (bvalid === 1'b1 && bready && bq.size() > 0)
    begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid === 1'b1 && rready && rq.size() > 0)
    begin
      er = rq.pop_front();
      `CHK("rresp", er[33:32], rresp)
      `CHK("rdata", er[31:0], rdata)
    end
  end

  task automatic wrap_up();
    begin
      $display("comparisons %0d mismatches %0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task automatic hang();
    begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] e);
    int n;
    begin
      n = 0;
      bq.push_back(e);
      awaddr <= {idx, 2'h0};
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
        @(posedge ref_clk);
        n++;
        if (awvalid && awready === 1'b1) awvalid <= 1'b0;
        if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      @(posedge ref_clk);
      if (n >= 50) hang();
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] e);
    int n;
    begin
      n = 0;
      rq.push_back({e, d});
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge ref_clk);
        n++;
        if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      @(posedge ref_clk);
      if (n >= 50) hang();
    end
  endtask

  task automatic apply();
    int n;
    begin
      n = 0;
      wr(`MBT_IDX_APPLY, 32'h1, `MBT_RESP_OKAY);
      while (configBusy !== 1'b0 && n < 20)
      begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 20) hang();
    end
  endtask

  task automatic cfg(input logic [31:0] sel, input logic [31:0] tmo);
    begin
      wr(`MBT_IDX_TIMEOUT, tmo, `MBT_RESP_OKAY);
      wr(`MBT_IDX_RESTART_SEL, sel, `MBT_RESP_OKAY);
      apply();
    end
  endtask

  initial
  begin
    lv = rnd();
    tableRevision = lv[15:0];
    driveTypeCode = lv[31:16];
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(`MBT_IDX_TIMEOUT, 32'h14, `MBT_RESP_OKAY);
    rd(`MBT_IDX_RESTART_SEL, 32'h2, `MBT_RESP_OKAY);
    rd(`MBT_IDX_HALF_ORDER, 32'h1, `MBT_RESP_OKAY);
    rd(`MBT_IDX_APPLY, 32'h0, `MBT_RESP_OKAY);
    wr(`MBT_IDX_TABLE_REV, 32'hFFFF, `MBT_RESP_OKAY);
    rd(`MBT_IDX_TABLE_REV, {16'h0, tableRevision}, `MBT_RESP_OKAY);
    wr(`MBT_IDX_TYPE_CODE, ~lv, `MBT_RESP_OKAY);
    rd(`MBT_IDX_TYPE_CODE, {16'h0, driveTypeCode}, `MBT_RESP_OKAY);
    for (int i = `MBT_IDX_RSVD_FIRST; i <= `MBT_IDX_RSVD_LAST; i++)
    begin
      wr(8'(i), 32'hFFFF, `MBT_RESP_OKAY);
      rd(8'(i), 32'h0, `MBT_RESP_OKAY);
    end
    wr(8'h30, 32'h1, `MBT_RESP_SLVERR);
    rd(8'h30, 32'h0, `MBT_RESP_SLVERR);
    $display("test registers done");
    lv = rnd();
    wr(`MBT_IDX_LONG_VALUE, lv, `MBT_RESP_OKAY);
    rd(`MBT_IDX_TX_WORDS, lv, `MBT_RESP_OKAY);
    `CHK("txByteStream", lv, txByteStream)
    wr(`MBT_IDX_HALF_ORDER, 32'h0, `MBT_RESP_OKAY);
    apply();
    rd(`MBT_IDX_APPLY, 32'h0, `MBT_RESP_OKAY);
    rd(`MBT_IDX_TX_WORDS, {lv[15:0], lv[31:16]}, `MBT_RESP_OKAY);
    `CHK("firstRegWord", lv[15:0], firstRegWord)
    `CHK("secondRegWord", lv[31:16], secondRegWord)
    `CHK("txByteStream", {lv[15:8], lv[7:0], lv[31:24], lv[23:16]}, txByteStream)
    $display("test word order done");
    u_client.set_run(1'b1);
    wr(`MBT_IDX_APPLY, 32'h1, `MBT_RESP_SLVERR);
    `CHK("configBusy", 1'b0, configBusy)
    rd(`MBT_IDX_APPLY, 32'h0, `MBT_RESP_OKAY);
    rd(`MBT_IDX_STATUS, 32'h2, `MBT_RESP_OKAY);
    u_client.set_run(1'b0);
    $display("test apply done");
    cfg(32'h1, 32'h3);
    u_client.send(4'h2);
    repeat (25) @(posedge ref_clk);
    `CHK("commLost", 1'b0, commLost)
    repeat (10) @(posedge ref_clk);
    `CHK("commLost", 1'b1, commLost)
    u_client.send(4'h8);
    repeat (2) @(posedge ref_clk);
    `CHK("commLost", 1'b0, commLost)
    cfg(32'h2, 32'h3);
    foreach (kinds[k])
    begin
      repeat (35) @(posedge ref_clk);
      `CHK("commLost", 1'b1, commLost)
      u_client.send(kinds[k]);
      repeat (2) @(posedge ref_clk);
      `CHK("commLost", kinds[k] == 4'h8, commLost)
    end
    cfg(32'h0, 32'h3);
    repeat (50) @(posedge ref_clk);
    `CHK("commLost", 1'b0, commLost)
    cfg(32'h1, 32'h0);
    repeat (50) @(posedge ref_clk);
    `CHK("commLost", 1'b0, commLost)
    $display("test supervision done");
    // A rejected select must leave the disabled settings in force and flag the error.
    cfg(32'h3, 32'h3);
    repeat (40) @(posedge ref_clk);
    `CHK("commLost", 1'b0, commLost)
    rd(`MBT_IDX_STATUS, 32'h8, `MBT_RESP_OKAY);
    rd(`MBT_IDX_RESTART_SEL, 32'h3, `MBT_RESP_OKAY);
    rd(`MBT_IDX_LONG_VALUE, lv, `MBT_RESP_OKAY);
    $display("test validation done");
    wrap_up();
  end
endmodule
